/* File: mmrra_pkg.sv */
package mmrra_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Sizes of the interconnect.
   localparam int NUM_MASTERS = 4;
   localparam int NUM_LAYERS = 5;
   localparam int NUM_DMA = 2;
   localparam int NUM_STREAMS = 8;
   localparam int NUM_PORTS = 2;
   localparam int NUM_BRIDGES = 2;
   localparam int BR_PORTS = 2;

   ////////////////////////////////////////////////////////////////////////////////
   // Index positions inside the grant vectors.
   localparam int PORT_MEM = 0;
   localparam int PORT_PER = 1;
   localparam int BR_DIRECT = 0;
   localparam int BR_COMMON = 1;
   localparam int DMA_FIRST = 0;
   localparam int DMA_SECOND = 1;

   ////////////////////////////////////////////////////////////////////////////////
   // FIFO levels and transfer direction codes.
   localparam logic [2:0] FIFO_EMPTY = 3'h0;
   localparam logic [2:0] FIFO_FULL = 3'h4;
   localparam logic [2:0] THRESH_STEP = 3'h1;
   localparam logic DIR_P2M = 1'b0;
   localparam logic DIR_M2P = 1'b1;
   localparam logic [1:0] RESET_OWNER_OFS = 2'h1;

   typedef enum logic [1:0] {
      M_CPU = 2'b00,
      M_FIRST_DMA_UNIT_MEM = 2'b01,
      M_SECOND_DMA_UNIT_MEM = 2'b10,
      M_SECOND_DMA_UNIT_PER = 2'b11
   } mmrra_master_e;

   typedef enum logic [2:0] {
      L_FLASH = 3'b000,
      L_SRAM = 3'b001,
      L_EXTMEM = 3'b010,
      L_BRIDGE1 = 3'b011,
      L_BRIDGE2 = 3'b100
   } mmrra_layer_e;

   typedef enum logic [1:0] {
      TH_QUARTER = 2'b00,
      TH_HALF = 2'b01,
      TH_3QUARTER = 2'b10,
      TH_FULL = 2'b11
   } mmrra_thresh_e;

   ////////////////////////////////////////////////////////////////////////////////
   // Carriers.
   typedef struct packed {
      logic req;
      mmrra_layer_e target;
      logic lock;
      logic last;
   } mmrra_mreq_s;

   typedef struct packed {
      logic enable;
      logic [1:0] stream_priority_level;
      mmrra_thresh_e thresh;
      logic dir;
      logic direct_mode;
   } mmrra_scfg_s;

   typedef struct packed {
      logic periph_req;
      logic [2:0] fifo_level;
   } mmrra_sstat_s;

   typedef struct packed {
      logic valid;
      logic [2:0] stream;
   } mmrra_sgrant_s;

endpackage

/* File: mmrra_rr_arb.sv */
`timescale 1ns/1ps
module mmrra_rr_arb #(
   parameter int N = 4
) (
   input wire logic core_clk_in, // Clock.
   input wire logic resetn_in, // Asynchronous reset, active low.
   input wire logic ce_in, // Clock enable.
   input wire logic [N-1:0] req_in, // Requests.
   input wire logic done_in, // Owner ends a transfer this cycle.
   input wire logic lock_in, // Owner keeps the slave after this transfer.
   output logic [N-1:0] grant_out // One-hot grant, registered.
);
   import mmrra_pkg::*;

   localparam int IW = (N > 1) ? $clog2(N) : 1;

   logic [IW-1:0] last_owner;
   logic [N-1:0] next_grant;
   logic [IW-1:0] next_owner;
   wire owner_req = |(grant_out & req_in);
   // An owner that drops its request gives the slave up at once.
   wire release_now = !owner_req || (done_in && !lock_in);

   // Search starts just after the last owner so that it comes last.
   always_comb begin
      int idx;
      idx = 0;
      next_grant = '0;
      next_owner = last_owner;
      for (int i = N; i >= 1; i--) begin
         idx = (int'(last_owner) + i) % N;
         if (req_in[idx]) begin
            next_grant = '0;
            next_grant[idx] = 1'b1;
            next_owner = IW'(idx);
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         grant_out <= '0;
         last_owner <= IW'(N - 1);
      end else if (ce_in && release_now) begin
         grant_out <= next_grant;
         last_owner <= next_owner;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   property p_single_owner;
      @(posedge core_clk_in) disable iff (!resetn_in)
      $onehot0(grant_out);
   endproperty
   a_single_owner: assert property (p_single_owner) else $error("two owners");

   property p_hold;
      @(posedge core_clk_in) disable iff (!resetn_in)
      (ce_in && owner_req && (lock_in || !done_in)) |=> $stable(grant_out);
   endproperty
   a_hold: assert property (p_hold) else $error("grant moved mid sequence");

   property p_rotate;
      @(posedge core_clk_in) disable iff (!resetn_in)
      (ce_in && owner_req && done_in && !lock_in && |(req_in & ~grant_out))
         |=> (grant_out != $past(grant_out));
   endproperty
   a_rotate: assert property (p_rotate) else $error("no rotation");

   c_locked: cover property (@(posedge core_clk_in) disable iff (!resetn_in)
      ce_in && owner_req && done_in && lock_in && |(req_in & ~grant_out));

endmodule

/* File: mmrra_dma_arb.sv */
`timescale 1ns/1ps
module mmrra_dma_arb (
   input wire logic core_clk_in, // Clock.
   input wire logic resetn_in, // Asynchronous reset, active low.
   input wire logic ce_in, // Clock enable.
   input wire logic [mmrra_pkg::NUM_STREAMS-1:0] req_in, // Stream requests.
   input wire logic [mmrra_pkg::NUM_STREAMS-1:0][1:0] prio_in, // Stream priorities.
   input wire logic last_in, // Last data cycle of the served stream.
   output mmrra_pkg::mmrra_sgrant_s grant_out // Served stream, registered.
);
   import mmrra_pkg::*;

   logic [NUM_STREAMS-1:0] served;
   logic [NUM_STREAMS-1:0] masked_req;
   logic best_found;
   logic [2:0] best_idx;
   logic [1:0] best_prio;

   // The served stream is hidden while it finishes so a rival can win.
   assign served = grant_out.valid ? ({{(NUM_STREAMS-1){1'b0}}, 1'b1} << grant_out.stream) : '0;
   assign masked_req = req_in & ~served;
   wire rearb = !grant_out.valid || last_in;

   // Scanning downwards with >= lets the lower index win a tie.
   always_comb begin
      best_found = 1'b0;
      best_idx = 3'h0;
      best_prio = 2'h0;
      for (int i = NUM_STREAMS - 1; i >= 0; i--) begin
         if (masked_req[i] && (!best_found || prio_in[i] >= best_prio)) begin
            best_found = 1'b1;
            best_idx = 3'(i);
            best_prio = prio_in[i];
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         grant_out <= '0;
      end else if (ce_in && rearb) begin
         grant_out <= {best_found, best_idx};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   property p_grant_next;
      @(posedge core_clk_in) disable iff (!resetn_in)
      (ce_in && !grant_out.valid && |req_in) |=> grant_out.valid;
   endproperty
   a_grant_next: assert property (p_grant_next) else $error("late grant");

   property p_mask_served;
      @(posedge core_clk_in) disable iff (!resetn_in)
      (ce_in && grant_out.valid && last_in)
         |=> !(grant_out.valid && grant_out.stream == $past(grant_out.stream));
   endproperty
   a_mask_served: assert property (p_mask_served) else $error("served re-won");

   property p_tie_low;
      @(posedge core_clk_in) disable iff (!resetn_in)
      (ce_in && rearb && masked_req[0] && masked_req[1] && prio_in[0] == prio_in[1])
         |=> (grant_out.stream != 3'h1);
   endproperty
   a_tie_low: assert property (p_tie_low) else $error("tie went high");

   c_switch: cover property (@(posedge core_clk_in) disable iff (!resetn_in)
      ce_in && grant_out.valid && last_in && |masked_req);

endmodule

/* File: mmrra_top.sv */
`timescale 1ns/1ps
module mmrra_top (
   input wire logic core_clk_in, // Clock, 100 MHz.
   input wire logic resetn_in, // Asynchronous reset, active low.
   input wire logic ce_in, // Clock enable; low freezes all state.
   input mmrra_pkg::mmrra_mreq_s [mmrra_pkg::NUM_MASTERS-1:0] mreq_in, // Matrix requests.
   input wire logic first_dma_unit_per_req_in, // First DMA peripheral port to bridge one.
   input wire logic [mmrra_pkg::NUM_BRIDGES-1:0] apb_done_in, // APB transfer ends.
   input mmrra_pkg::mmrra_scfg_s [mmrra_pkg::NUM_DMA-1:0][mmrra_pkg::NUM_STREAMS-1:0]
      stream_cfg_in, // Stream setup.
   input mmrra_pkg::mmrra_sstat_s [mmrra_pkg::NUM_DMA-1:0][mmrra_pkg::NUM_STREAMS-1:0]
      stream_stat_in, // Stream request and FIFO level.
   input wire logic [mmrra_pkg::NUM_DMA-1:0][mmrra_pkg::NUM_PORTS-1:0]
      port_last_in, // Last data cycle on a DMA port.
   output logic [mmrra_pkg::NUM_LAYERS-1:0][mmrra_pkg::NUM_MASTERS-1:0]
      layer_grant_out, // Matrix grants.
   output logic [mmrra_pkg::NUM_BRIDGES-1:0][mmrra_pkg::BR_PORTS-1:0]
      bridge_grant_out, // Bridge grants.
   output mmrra_pkg::mmrra_sgrant_s [mmrra_pkg::NUM_DMA-1:0][mmrra_pkg::NUM_PORTS-1:0]
      dma_grant_out // Stream served on each DMA port.
);
   import mmrra_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Which matrix layers each master may address.
   function automatic logic reach(input int m, input int l);
      reach = 1'b1;
      if (m == int'(M_FIRST_DMA_UNIT_MEM) && l >= int'(L_BRIDGE1)) begin
         reach = 1'b0;
      end
      // Bridge two is reached over the direct path instead.
      if (m == int'(M_SECOND_DMA_UNIT_PER) && l == int'(L_BRIDGE2)) begin
         reach = 1'b0;
      end
   endfunction

   function automatic logic [2:0] thresh_words(input mmrra_thresh_e t);
      thresh_words = {1'b0, t} + THRESH_STEP;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Matrix: one independent arbiter per layer.
   logic [NUM_MASTERS-1:0] m_req;
   logic [NUM_MASTERS-1:0] m_last;
   logic [NUM_MASTERS-1:0] m_lock;
   logic [NUM_LAYERS-1:0][NUM_MASTERS-1:0] layer_req;
   logic [NUM_LAYERS-1:0] layer_done;
   logic [NUM_LAYERS-1:0] layer_lock;

   genvar m, l, b, u, s, p;
   generate
      for (m = 0; m < NUM_MASTERS; m++) begin : g_mst
         assign m_req[m] = mreq_in[m].req;
         assign m_last[m] = mreq_in[m].last;
         assign m_lock[m] = mreq_in[m].lock;
         for (l = 0; l < NUM_LAYERS; l++) begin : g_lay
            assign layer_req[l][m] = mreq_in[m].req && reach(m, l) &&
               (mreq_in[m].target == 3'(l));
         end
      end

      for (l = 0; l < NUM_LAYERS; l++) begin : g_layer
         // A burst or multi-word access ends only on its final word.
         assign layer_done[l] = |(layer_grant_out[l] & m_last);
         assign layer_lock[l] = |(layer_grant_out[l] & m_lock);
         mmrra_rr_arb #(
            .N(NUM_MASTERS)
         ) u_layer_arb (
            .core_clk_in(core_clk_in),
            .resetn_in(resetn_in),
            .ce_in(ce_in),
            .req_in(layer_req[l]),
            .done_in(layer_done[l]),
            .lock_in(layer_lock[l]),
            .grant_out(layer_grant_out[l])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Bridges: direct DMA path against the common matrix path.
   logic [NUM_BRIDGES-1:0][BR_PORTS-1:0] bridge_req;

   // The common path is busy while its matrix layer owner still requests.
   assign bridge_req[0][BR_COMMON] = |(layer_grant_out[L_BRIDGE1] & m_req);
   assign bridge_req[1][BR_COMMON] = |(layer_grant_out[L_BRIDGE2] & m_req);
   assign bridge_req[0][BR_DIRECT] = first_dma_unit_per_req_in;
   assign bridge_req[1][BR_DIRECT] = mreq_in[M_SECOND_DMA_UNIT_PER].req &&
      (mreq_in[M_SECOND_DMA_UNIT_PER].target == L_BRIDGE2);

   generate
      for (b = 0; b < NUM_BRIDGES; b++) begin : g_bridge
         // No lock here: every APB transfer is a full quantum.
         mmrra_rr_arb #(
            .N(BR_PORTS)
         ) u_bridge_arb (
            .core_clk_in(core_clk_in),
            .resetn_in(resetn_in),
            .ce_in(ce_in),
            .req_in(bridge_req[b]),
            .done_in(apb_done_in[b]),
            .lock_in(1'b0),
            .grant_out(bridge_grant_out[b])
         );

         property p_bridge_bound;
            @(posedge core_clk_in) disable iff (!resetn_in)
            (ce_in && bridge_grant_out[b][BR_COMMON] && apb_done_in[b] &&
               bridge_req[b][BR_DIRECT]) |=> bridge_grant_out[b][BR_DIRECT];
         endproperty
         a_bridge_bound: assert property (p_bridge_bound) else $error("DMA waited");

         c_bridge_both: cover property (@(posedge core_clk_in) disable iff (!resetn_in)
            ce_in && bridge_req[b][BR_DIRECT] && bridge_req[b][BR_COMMON]);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // DMA units: stream requests per port and the priority arbiters.
   logic [NUM_DMA-1:0][NUM_PORTS-1:0][NUM_STREAMS-1:0] port_req;
   logic [NUM_DMA-1:0][NUM_STREAMS-1:0][1:0] stream_prio;

   generate
      for (u = 0; u < NUM_DMA; u++) begin : g_dma
         for (s = 0; s < NUM_STREAMS; s++) begin : g_str
            wire lvl_nz = stream_stat_in[u][s].fifo_level != FIFO_EMPTY;
            wire lvl_full = stream_stat_in[u][s].fifo_level >= FIFO_FULL;
            wire thr_met = stream_stat_in[u][s].fifo_level >=
               thresh_words(stream_cfg_in[u][s].thresh);
            wire en = stream_cfg_in[u][s].enable;
            wire drct = stream_cfg_in[u][s].direct_mode;
            wire p2m = stream_cfg_in[u][s].dir == DIR_P2M;
            wire preq = stream_stat_in[u][s].periph_req;
            // Inbound: the memory side drains on threshold, or at once when direct.
            wire mem_p2m = drct ? lvl_nz : thr_met;
            // Outbound: memory refills the FIFO ahead of the peripheral.
            wire mem_m2p = drct ? !lvl_nz : !lvl_full;
            wire per_p2m = preq && (drct ? !lvl_nz : !lvl_full);
            wire per_m2p = preq && lvl_nz;
            assign port_req[u][PORT_MEM][s] = en && (p2m ? mem_p2m : mem_m2p);
            assign port_req[u][PORT_PER][s] = en && (p2m ? per_p2m : per_m2p);
            assign stream_prio[u][s] = stream_cfg_in[u][s].stream_priority_level;
         end

         // The two ports of a unit are arbitrated apart and run in parallel.
         for (p = 0; p < NUM_PORTS; p++) begin : g_port
            mmrra_dma_arb u_dma_arb (
               .core_clk_in(core_clk_in),
               .resetn_in(resetn_in),
               .ce_in(ce_in),
               .req_in(port_req[u][p]),
               .prio_in(stream_prio[u]),
               .last_in(port_last_in[u][p]),
               .grant_out(dma_grant_out[u][p])
            );
         end

         c_dual_port: cover property (@(posedge core_clk_in) disable iff (!resetn_in)
            dma_grant_out[u][PORT_MEM].valid && dma_grant_out[u][PORT_PER].valid);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   property p_cpu_then_first_dma_unit;
      @(posedge core_clk_in) disable iff (!resetn_in)
      (ce_in && layer_grant_out[L_SRAM][M_CPU] && mreq_in[M_CPU].req &&
         mreq_in[M_CPU].last && !mreq_in[M_CPU].lock && layer_req[L_SRAM][M_FIRST_DMA_UNIT_MEM])
         |=> layer_grant_out[L_SRAM][M_FIRST_DMA_UNIT_MEM];
   endproperty
   a_cpu_then_first_dma_unit: assert property (p_cpu_then_first_dma_unit) else $error("FIRST_DMA_UNIT skipped");

   property p_first_dma_unit_reach;
      @(posedge core_clk_in) disable iff (!resetn_in)
      !layer_grant_out[L_BRIDGE1][M_FIRST_DMA_UNIT_MEM] && !layer_grant_out[L_BRIDGE2][M_FIRST_DMA_UNIT_MEM];
   endproperty
   a_first_dma_unit_reach: assert property (p_first_dma_unit_reach) else $error("FIRST_DMA_UNIT on bridge");

   property p_second_dma_unit_direct;
      @(posedge core_clk_in) disable iff (!resetn_in)
      !layer_grant_out[L_BRIDGE2][M_SECOND_DMA_UNIT_PER];
   endproperty
   a_second_dma_unit_direct: assert property (p_second_dma_unit_direct) else $error("SECOND_DMA_UNIT via matrix");

   property p_burst_kept;
      @(posedge core_clk_in) disable iff (!resetn_in)
      (ce_in && layer_grant_out[L_SRAM][M_SECOND_DMA_UNIT_MEM] && mreq_in[M_SECOND_DMA_UNIT_MEM].req &&
         mreq_in[M_SECOND_DMA_UNIT_MEM].lock)
         |=> layer_grant_out[L_SRAM][M_SECOND_DMA_UNIT_MEM] || !$past(ce_in);
   endproperty
   a_burst_kept: assert property (p_burst_kept) else $error("burst broken");

   c_concurrent: cover property (@(posedge core_clk_in) disable iff (!resetn_in)
      |layer_grant_out[L_SRAM] && |layer_grant_out[L_FLASH]);

endmodule

/* File: mmrra_mst_model.sv */
`timescale 1ns/1ps
// One bus master on a matrix port. It reacts one edge after its grant on purpose,
// so the arbiter is never allowed to rely on a master answering in the grant cycle.
module mmrra_mst_model (
   input wire logic core_clk_in, // Clock.
   input wire logic [mmrra_pkg::NUM_LAYERS-1:0] grant_in, // Own grant bit per layer.
   output mmrra_pkg::mmrra_mreq_s mreq_out // Request to the matrix.
);
   import mmrra_pkg::*;
   int edges = 0;
   int t_grant; // Edge of the first grant, -1 if none came.
   int held; // Edges on which the grant was seen high.
   initial mreq_out = '0;
   always @(posedge core_clk_in) edges <= edges + 1;
   ////////////////////////////////////////////////////////////////////////////////
   // Every word ends a transfer; lock keeps the slave for the word after it.
   task automatic xfer(input mmrra_layer_e tgt, input int words);
      int n;
      // One idle edge first, so that a call right after another never writes twice per step.
      @(posedge core_clk_in);
      t_grant = -1;
      held = 0;
      mreq_out <= '{req: 1'b1, target: tgt, lock: 1'b0, last: 1'b0};
      for (n = 0; n < 40; n++) begin
         @(posedge core_clk_in);
         if (grant_in[tgt] === 1'b1) break;
      end
      if (n < 40) begin
         t_grant = edges;
         for (n = 1; n <= words; n++) begin
            held += int'(grant_in[tgt]);
            mreq_out.last <= 1'b1;
            mreq_out.lock <= (n < words);
            @(posedge core_clk_in);
         end
         held += int'(grant_in[tgt]);
      end
      mreq_out <= '0;
   endtask
endmodule

/* File: tb_multi_master_round_robin_arbitration.sv */
`timescale 1ns/1ps
module tb_multi_master_round_robin_arbitration;
   import mmrra_pkg::*;
   logic clk;
   logic rstn;
   logic ce;
   logic dper;
   logic [NUM_BRIDGES-1:0] done;
   mmrra_scfg_s [NUM_DMA-1:0][NUM_STREAMS-1:0] cfg;
   mmrra_sstat_s [NUM_DMA-1:0][NUM_STREAMS-1:0] stat;
   logic [NUM_DMA-1:0][NUM_PORTS-1:0] plast;
   wire mmrra_mreq_s [NUM_MASTERS-1:0] mreq;
   logic [NUM_LAYERS-1:0][NUM_MASTERS-1:0] lg;
   logic [NUM_BRIDGES-1:0][BR_PORTS-1:0] bg;
   mmrra_sgrant_s [NUM_DMA-1:0][NUM_PORTS-1:0] dg;
   logic bad_reach = 1'b0;
   logic [31:0] r;
   int err_total = 0;
   int checked = 0;
   integer seed = 32'h1423;
   int cur [NUM_DMA][NUM_PORTS];
   int wl [2] = '{8, 14};

   mmrra_top i_mmrra_top (
      .core_clk_in(clk), .resetn_in(rstn), .ce_in(ce), .mreq_in(mreq),
      .first_dma_unit_per_req_in(dper), .apb_done_in(done), .stream_cfg_in(cfg),
      .stream_stat_in(stat), .port_last_in(plast), .layer_grant_out(lg),
      .bridge_grant_out(bg), .dma_grant_out(dg)
   );

   for (genvar gm = 0; gm < NUM_MASTERS; gm++) begin : m
      wire [NUM_LAYERS-1:0] g;
      for (genvar gl = 0; gl < NUM_LAYERS; gl++) begin : l
         // Bridge two is reached by the second DMA peripheral port on its direct path.
         assign g[gl] = (gm == 3 && gl == 4) ? bg[1][0] : lg[gl][gm];
      end
      mmrra_mst_model u (.core_clk_in(clk), .grant_in(g), .mreq_out(mreq[gm]));
   end

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) if ((lg[3][1] | lg[4][1] | lg[4][3]) === 1'b1) bad_reach <= 1'b1;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic chk_grant(input int u, input int p);
      chk(dg[u][p].valid, cur[u][p] >= 0);
      if (cur[u][p] >= 0) chk(dg[u][p].stream, cur[u][p]);
   endtask

   task automatic finish_test();
      $display("checked=%0d err_total=%0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Reference of a stream's request on one DMA port.
   function automatic bit sreq(input int u, input int p, input int s);
      mmrra_scfg_s c;
      int lv;
      c = cfg[u][s];
      lv = stat[u][s].fifo_level;
      if (!c.enable) return 1'b0;
      if (p == PORT_MEM) begin
         if (c.dir == DIR_P2M) return c.direct_mode ? lv != 0 : lv >= int'(c.thresh) + 1;
         return c.direct_mode ? lv == 0 : lv < 4;
      end
      if (c.dir == DIR_P2M) return stat[u][s].periph_req && (c.direct_mode ? lv == 0 : lv < 4);
      return stat[u][s].periph_req && lv != 0;
   endfunction

   // Strict compare keeps the lower index on a tie; the masked stream never wins.
   function automatic int best(input int u, input int p, input int mask);
      int w;
      w = -1;
      for (int s = 0; s < NUM_STREAMS; s++) begin
         if (s != mask && sreq(u, p, s) && (w < 0 ||
             cfg[u][s].stream_priority_level > cfg[u][w].stream_priority_level)) w = s;
      end
      return w;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rstn = 1'b0;
      ce = 1'b1;
      dper = 1'b0;
      done = '0;
      cfg = '0;
      stat = '0;
      plast = '0;
      step(16);
      rstn <= 1'b1;
      step(2);
      fork
         m[0].u.xfer(L_SRAM, 1);
         m[1].u.xfer(L_SRAM, 1);
      join
      chk(m[1].u.t_grant - m[0].u.t_grant, 2);
      fork
         m[0].u.xfer(L_SRAM, 1);
         m[1].u.xfer(L_SRAM, 1);
         m[2].u.xfer(L_SRAM, 1);
      join
      chk(m[0].u.t_grant - m[2].u.t_grant, 2);
      chk(m[1].u.t_grant - m[0].u.t_grant, 2);
      foreach (wl[i]) begin
         fork
            m[0].u.xfer(L_SRAM, wl[i]);
            begin
               step(1);
               m[1].u.xfer(L_SRAM, 1);
            end
         join
         chk(m[0].u.held, wl[i] + 1);
         chk(m[1].u.t_grant - m[0].u.t_grant, wl[i] + 1);
      end
      fork
         m[0].u.xfer(L_FLASH, 1);
         m[1].u.xfer(L_SRAM, 1);
         m[2].u.xfer(L_EXTMEM, 1);
         m[3].u.xfer(L_BRIDGE1, 1);
      join
      chk(m[1].u.t_grant - m[0].u.t_grant, 0);
      chk(m[2].u.t_grant - m[0].u.t_grant, 0);
      chk(m[3].u.t_grant - m[0].u.t_grant, 0);
      fork
         m[1].u.xfer(L_BRIDGE1, 1);
         m[3].u.xfer(L_BRIDGE2, 1);
      join
      chk(m[1].u.t_grant, -1);
      chk(m[3].u.t_grant >= 0, 1);
      done <= '1;
      step(1);
      done <= '0;
      // The processor keeps the common path busy while the direct path asks too.
      fork
         m[0].u.xfer(L_BRIDGE1, 12);
         begin
            dper <= 1'b1;
            step(3);
            for (int i = 0; i < 4; i++) begin
               // Look at the settled grant, away from the edge that launches it.
               @(negedge clk);
               chk(bg[0], i[0] ? 2'h2 : 2'h1);
               @(posedge clk);
               done[0] <= 1'b1;
               step(1);
               done[0] <= 1'b0;
               step(1);
            end
            dper <= 1'b0;
         end
      join
      foreach (cur[u, p]) cur[u][p] = -1;
      repeat (30) begin
         @(posedge clk);
         for (int u = 0; u < NUM_DMA; u++) begin
            for (int s = 0; s < NUM_STREAMS; s++) begin
               r = $random(seed);
               cfg[u][s] <= {r[6] | r[7], r[5:0]};
               stat[u][s] <= {r[11], 3'(r[10:8] % 5)};
            end
         end
         step(1);
         @(negedge clk);
         foreach (cur[u, p]) begin
            if (cur[u][p] < 0) cur[u][p] = best(u, p, -1);
            chk_grant(u, p);
         end
         @(posedge clk);
         plast <= '1;
         @(posedge clk);
         foreach (cur[u, p]) cur[u][p] = best(u, p, cur[u][p]);
         plast <= '0;
         cfg <= '0;
         @(negedge clk);
         foreach (cur[u, p]) chk_grant(u, p);
      end
      chk(bad_reach, 1'b0);
      finish_test();
   end
endmodule
